// >>> rtl/nvps_defs.svh
/*
 * Constants of the nonvolatile page save/restore block: control register
 * address and bits, bank mapping, erased value and store timing.
 * Assumes inclusion by bare name from the design modules (store and top).
 */
`ifndef NVPS_DEFS_SVH
`define NVPS_DEFS_SVH

`define NVPS_CTRL_ADDR 8'h3A
`define NVPS_CTRL_RESET 8'h00
`define NVPS_TRIG_MASK 8'h33
`define NVPS_SAVE1_BIT 0
`define NVPS_SAVE2_BIT 1
`define NVPS_LOAD1_BIT 4
`define NVPS_LOAD2_BIT 5
`define NVPS_BUSY_BIT 7
`define NVPS_PAGE1_BASE 8'h01
`define NVPS_PAGE2_BASE 8'h11
`define NVPS_ERASED 8'hFF
`define NVPS_STORE_BYTES 32
`define NVPS_PAGE_BYTES 16
`define NVPS_ERASE_CYCLES 16
`define NVPS_PROG_CYCLES 4
`define NVPS_READ_CYCLES 1

`endif

// >>> rtl/nvps_pkg.sv
/*
 * Types shared by the page save/restore controller and its store array.
 * Assumes a 32-byte store split into two 16-byte pages.
 */
package nvps_pkg;

    typedef enum logic [1:0] {
        NVPS_OP_READ = 2'h0,
        NVPS_OP_ERASE = 2'h1,
        NVPS_OP_PROG = 2'h2
    } nvps_op_t;

    typedef struct packed {
        nvps_op_t op;
        logic [4:0] addr;
        logic [7:0] data;
    } nvps_cmd_t;

    typedef enum logic [2:0] {
        NVPS_IDLE = 3'h0,
        NVPS_ERASE = 3'h1,
        NVPS_BANK_RD = 3'h3,
        NVPS_PROG = 3'h2,
        NVPS_NV_RD = 3'h6,
        NVPS_BANK_WR = 3'h7
    } nvps_state_t;

endpackage

// >>> rtl/nvps_store.sv
/*
 * Flip-flop nonvolatile store: 32 bytes in two pages, with page erase,
 * byte program and byte read, each taking a fixed number of cycles.
 * Assumes one command at a time: start is only given while not busy.
 */
`timescale 1ns/10ps
`include "nvps_defs.svh"

module nvps_store #(
    parameter int DEPTH = `NVPS_STORE_BYTES,
    parameter int PAGE_BYTES = `NVPS_PAGE_BYTES,
    parameter int ERASE_CYCLES = `NVPS_ERASE_CYCLES,
    parameter int PROG_CYCLES = `NVPS_PROG_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // command
    input wire logic start_in,
    input nvps_pkg::nvps_cmd_t cmd_in,
    // answer
    output logic done_out,
    output logic [7:0] rdata_out
);

    // the cycle counter is 16 bits wide, so longer timings cannot be served
    if (DEPTH != 2 * PAGE_BYTES || DEPTH != 32 || ERASE_CYCLES < 1 || PROG_CYCLES < 1 ||
        ERASE_CYCLES > 65536 || PROG_CYCLES > 65536) begin : g_bad_param
        $error("nvps_store: unsupported geometry or timing");
    end

    logic [7:0] mem_reg [DEPTH];
    logic [7:0] mem_next [DEPTH];
    logic [15:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [7:0] rdata_reg, rdata_next;
    nvps_pkg::nvps_cmd_t cmd_reg, cmd_next;

    function automatic logic [15:0] op_cycles(input nvps_pkg::nvps_op_t op);
        unique case (op)
            nvps_pkg::NVPS_OP_ERASE: op_cycles = 16'(ERASE_CYCLES - 1);
            nvps_pkg::NVPS_OP_PROG: op_cycles = 16'(PROG_CYCLES - 1);
            default: op_cycles = 16'(`NVPS_READ_CYCLES - 1);
        endcase
    endfunction

    always_comb begin
        int base;
        base = int'(cmd_reg.addr) & ~(PAGE_BYTES - 1);
        mem_next = mem_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        cmd_next = cmd_reg;
        if (busy_reg) begin
            if (cnt_reg == 16'h0000) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                unique case (cmd_reg.op)
                    nvps_pkg::NVPS_OP_ERASE: begin
                        // whole page goes to the erased value at once
                        for (int i = 0; i < PAGE_BYTES; i++) begin
                            mem_next[base + i] = `NVPS_ERASED;
                        end
                    end
                    nvps_pkg::NVPS_OP_PROG: mem_next[cmd_reg.addr] = cmd_reg.data;
                    default: rdata_next = mem_reg[cmd_reg.addr];
                endcase
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else if (start_in) begin
            cmd_next = cmd_in;
            busy_next = 1'b1;
            cnt_next = op_cycles(cmd_in.op);
        end
    end

    // contents reset to erased: a flip-flop store cannot survive power loss
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= `NVPS_ERASED;
            end
            cnt_reg <= 16'h0000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= 8'h00;
            cmd_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            cmd_reg <= cmd_next;
        end
    end

    assign done_out = done_reg;
    assign rdata_out = rdata_reg;

endmodule

// >>> rtl/nvps_top.sv
/*
 * Page save/restore controller: control register at nvm_page_control, sequencing of
 * load, erase and program between the register bank and the store.
 * Assumes register accesses and bank read data come from logic on the
 * same clock; bank read data follows the bank address combinationally.
 */
`timescale 1ns/10ps
`include "nvps_defs.svh"

module nvps_top #(
    parameter int ERASE_CYCLES = `NVPS_ERASE_CYCLES,
    parameter int PROG_CYCLES = `NVPS_PROG_CYCLES
) (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // register access from the serial slave
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [7:0] REG_RDATA_OUT,
    // register bank side
    output logic [7:0] BANK_ADDR_OUT,
    output logic [7:0] BANK_WDATA_OUT,
    output logic BANK_WE_OUT,
    input wire logic [7:0] BANK_RDATA_IN,
    // status
    output logic BUSY_OUT
);

    localparam logic [3:0] LAST_IDX = 4'(`NVPS_PAGE_BYTES - 1);

    nvps_pkg::nvps_state_t state_reg, state_next;
    logic [7:0] pend_reg, pend_next;
    logic [7:0] act_reg, act_next;
    logic page_reg, page_next;
    logic [3:0] idx_reg, idx_next;
    logic issued_reg, issued_next;
    logic [7:0] data_reg, data_next;
    logic [7:0] baddr_reg, baddr_next;
    logic [7:0] bwdata_reg, bwdata_next;
    logic bwe_reg, bwe_next;
    logic busy_reg, busy_next;
    logic [7:0] rdata_reg, rdata_next;

    logic st_start;
    nvps_pkg::nvps_cmd_t st_cmd;
    logic st_done;
    logic [7:0] st_rdata;

    function automatic logic [7:0] bank_addr(input logic page, input logic [3:0] idx);
        bank_addr = (page ? `NVPS_PAGE2_BASE : `NVPS_PAGE1_BASE) + {4'h0, idx};
    endfunction

    // loads first, so a queued load then save of a page keeps its contents
    function automatic logic [7:0] pick(input logic [7:0] pend);
        pick = 8'h00;
        if (pend[`NVPS_LOAD1_BIT]) begin
            pick[`NVPS_LOAD1_BIT] = 1'b1;
        end else if (pend[`NVPS_LOAD2_BIT]) begin
            pick[`NVPS_LOAD2_BIT] = 1'b1;
        end else if (pend[`NVPS_SAVE1_BIT]) begin
            pick[`NVPS_SAVE1_BIT] = 1'b1;
        end else if (pend[`NVPS_SAVE2_BIT]) begin
            pick[`NVPS_SAVE2_BIT] = 1'b1;
        end
    endfunction

    nvps_store #(
        .DEPTH(`NVPS_STORE_BYTES),
        .PAGE_BYTES(`NVPS_PAGE_BYTES),
        .ERASE_CYCLES(ERASE_CYCLES),
        .PROG_CYCLES(PROG_CYCLES)
    ) u_store (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .start_in(st_start),
        .cmd_in(st_cmd),
        .done_out(st_done),
        .rdata_out(st_rdata)
    );

    always_comb begin
        logic finish;
        logic [7:0] sel;
        finish = 1'b0;
        sel = pick(pend_reg);
        state_next = state_reg;
        act_next = act_reg;
        page_next = page_reg;
        idx_next = idx_reg;
        issued_next = issued_reg;
        data_next = data_reg;
        baddr_next = baddr_reg;
        bwdata_next = bwdata_reg;
        bwe_next = 1'b0;
        st_start = 1'b0;
        st_cmd.op = nvps_pkg::NVPS_OP_READ;
        st_cmd.addr = {page_reg, idx_reg};
        st_cmd.data = data_reg;
        unique case (state_reg)
            nvps_pkg::NVPS_IDLE: begin
                // one operation at a time; others stay pending
                if (sel != 8'h00) begin
                    act_next = sel;
                    page_next = sel[`NVPS_LOAD2_BIT] | sel[`NVPS_SAVE2_BIT];
                    idx_next = 4'h0;
                    issued_next = 1'b0;
                    if (sel[`NVPS_LOAD1_BIT] | sel[`NVPS_LOAD2_BIT]) begin
                        state_next = nvps_pkg::NVPS_NV_RD;
                    end else begin
                        state_next = nvps_pkg::NVPS_ERASE;
                    end
                end
            end
            nvps_pkg::NVPS_ERASE: begin
                st_cmd.op = nvps_pkg::NVPS_OP_ERASE;
                if (!issued_reg) begin
                    st_start = 1'b1;
                    issued_next = 1'b1;
                end else if (st_done) begin
                    issued_next = 1'b0;
                    baddr_next = bank_addr(page_reg, idx_reg);
                    state_next = nvps_pkg::NVPS_BANK_RD;
                end
            end
            nvps_pkg::NVPS_BANK_RD: begin
                data_next = BANK_RDATA_IN;
                state_next = nvps_pkg::NVPS_PROG;
            end
            nvps_pkg::NVPS_PROG: begin
                st_cmd.op = nvps_pkg::NVPS_OP_PROG;
                if (!issued_reg) begin
                    st_start = 1'b1;
                    issued_next = 1'b1;
                end else if (st_done) begin
                    issued_next = 1'b0;
                    if (idx_reg == LAST_IDX) begin
                        finish = 1'b1;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                        baddr_next = bank_addr(page_reg, idx_reg + 4'h1);
                        state_next = nvps_pkg::NVPS_BANK_RD;
                    end
                end
            end
            nvps_pkg::NVPS_NV_RD: begin
                if (!issued_reg) begin
                    st_start = 1'b1;
                    issued_next = 1'b1;
                end else if (st_done) begin
                    issued_next = 1'b0;
                    baddr_next = bank_addr(page_reg, idx_reg);
                    bwdata_next = st_rdata;
                    bwe_next = 1'b1;
                    state_next = nvps_pkg::NVPS_BANK_WR;
                end
            end
            nvps_pkg::NVPS_BANK_WR: begin
                if (idx_reg == LAST_IDX) begin
                    finish = 1'b1;
                end else begin
                    idx_next = idx_reg + 4'h1;
                    state_next = nvps_pkg::NVPS_NV_RD;
                end
            end
            default: state_next = nvps_pkg::NVPS_IDLE;
        endcase
        if (finish) begin
            state_next = nvps_pkg::NVPS_IDLE;
            act_next = 8'h00;
        end
        // a trigger written in the finishing cycle survives: set wins
        pend_next = pend_reg & ~(finish ? act_reg : 8'h00);
        if (REG_WR_IN && REG_ADDR_IN == `NVPS_CTRL_ADDR) begin
            pend_next = pend_next | (REG_WDATA_IN & `NVPS_TRIG_MASK);
        end
        busy_next = (state_next != nvps_pkg::NVPS_IDLE);
        rdata_next = 8'h00;
        if (REG_RD_IN && REG_ADDR_IN == `NVPS_CTRL_ADDR) begin
            rdata_next = pend_reg;
            rdata_next[`NVPS_BUSY_BIT] = busy_reg;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= nvps_pkg::NVPS_IDLE;
            pend_reg <= `NVPS_CTRL_RESET;
            act_reg <= 8'h00;
            page_reg <= 1'b0;
            idx_reg <= 4'h0;
            issued_reg <= 1'b0;
            data_reg <= 8'h00;
            baddr_reg <= 8'h00;
            bwdata_reg <= 8'h00;
            bwe_reg <= 1'b0;
            busy_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            act_reg <= act_next;
            page_reg <= page_next;
            idx_reg <= idx_next;
            issued_reg <= issued_next;
            data_reg <= data_next;
            baddr_reg <= baddr_next;
            bwdata_reg <= bwdata_next;
            bwe_reg <= bwe_next;
            busy_reg <= busy_next;
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA_OUT = rdata_reg;
    assign BANK_ADDR_OUT = baddr_reg;
    assign BANK_WDATA_OUT = bwdata_reg;
    assign BANK_WE_OUT = bwe_reg;
    assign BUSY_OUT = busy_reg;

endmodule

// >>> tb/nvps_chk.sv
/*
 * Checker for the page save/restore controller: port-level properties.
 * Assumes it is bound to nvps_top and sees only that module's ports.
 */
`timescale 1ns/10ps

module nvps_chk #(
    parameter int ERASE_CYCLES = 16,
    parameter int PROG_CYCLES = 4
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic [7:0] BANK_ADDR_OUT,
    input wire logic [7:0] BANK_WDATA_OUT,
    input wire logic BANK_WE_OUT,
    input wire logic [7:0] BANK_RDATA_IN,
    input wire logic BUSY_OUT
);
    // generous: a load queued behind a save still ends well inside this
    localparam int MAX_OP = 1000;
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);

    // the trigger lands in the pending bits first, so busy shows two edges later
    a_trig_starts_busy: assert property (
        REG_WR_IN && REG_ADDR_IN == 8'h3A && (REG_WDATA_IN & 8'h33) != 8'h00 && !BUSY_OUT
        |=> ##1 BUSY_OUT)
        else $error("trigger write did not start an operation");
    a_busy_bounded: assert property ($rose(BUSY_OUT) |-> ##[1:MAX_OP] !BUSY_OUT)
        else $error("operation never finished");
    a_we_needs_busy: assert property (BANK_WE_OUT |-> BUSY_OUT)
        else $error("bank write outside an operation");
    a_we_single_pulse: assert property (BANK_WE_OUT |=> !BANK_WE_OUT)
        else $error("bank write strobe longer than one cycle");
    a_we_in_map: assert property (
        BANK_WE_OUT |-> BANK_ADDR_OUT >= 8'h01 && BANK_ADDR_OUT <= 8'h20)
        else $error("bank write outside the two page windows");
    a_rd_other_zero: assert property (
        REG_RD_IN && REG_ADDR_IN != 8'h3A |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read returned nonzero");
    a_rd_busy_bit: assert property (
        REG_RD_IN && REG_ADDR_IN == 8'h3A |=>
        REG_RDATA_OUT[7] == $past(BUSY_OUT) && REG_RDATA_OUT[3:2] == 2'h0)
        else $error("control read busy or reserved bits wrong");
    a_rd_no_strobe: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
        else $error("read data without a read strobe");
    a_reset_idle: assert property ($fell(RST_IN) |-> !BUSY_OUT && !BANK_WE_OUT)
        else $error("outputs not idle after reset");

    c_load: cover property (REG_WR_IN && REG_ADDR_IN == 8'h3A && REG_WDATA_IN[4]);
    c_save: cover property (REG_WR_IN && REG_ADDR_IN == 8'h3A && REG_WDATA_IN[1]);
    c_queued: cover property (REG_WR_IN && REG_ADDR_IN == 8'h3A && BUSY_OUT);
endmodule

bind nvps_top nvps_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) nvps_chk_i (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .BANK_ADDR_OUT(BANK_ADDR_OUT), .BANK_WDATA_OUT(BANK_WDATA_OUT), .BANK_WE_OUT(BANK_WE_OUT),
    .BANK_RDATA_IN(BANK_RDATA_IN), .BUSY_OUT(BUSY_OUT));

// >>> tb/nvps_bank_model.sv
/*
 * Register bank model: 256 bytes, combinational read, write on strobe.
 * Assumes the same clock as the controller; the bench may poke mem directly.
 */
`timescale 1ns/10ps

module nvps_bank_model (
    // clock
    input wire logic clk_in,
    // access
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic we_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [256];

    // each byte starts at its inverted address, so byte 0 starts at the erased value and byte 255 at zero
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~i[7:0];
        end
    end

    assign rdata_out = mem[addr_in];

    always @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end
endmodule

// >>> tb/testbench.sv
/*
 * Self-checking bench for nvps_top: register triggers, load, save, queueing.
 * Assumes the bank model stands on the bank port and short store timings.
 */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, bank_addr, bank_wdata, bank_rdata, rd;
    logic bank_we, busy;
    int err_count = 0;
    int n_checks = 0;

    nvps_top #(.ERASE_CYCLES(2), .PROG_CYCLES(2)) nvps_top_i (
        .CLK_SYS_IN(clk), .RST_IN(rst), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
        .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(reg_rdata),
        .BANK_ADDR_OUT(bank_addr), .BANK_WDATA_OUT(bank_wdata), .BANK_WE_OUT(bank_we),
        .BANK_RDATA_IN(bank_rdata), .BUSY_OUT(busy));
    nvps_bank_model nvps_bank_model_i (.clk_in(clk), .addr_in(bank_addr),
        .wdata_in(bank_wdata), .we_in(bank_we), .rdata_out(bank_rdata));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // each access ends with an idle cycle so strobes never re-rise in one step
    task automatic reg_wr_op(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(posedge clk); #1; reg_wr = 1'b0;
        @(posedge clk); #1;
    endtask

    task automatic reg_rd_op(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a; reg_rd = 1'b1;
        @(posedge clk); #1; reg_rd = 1'b0; d = reg_rdata;
        @(posedge clk); #1;
    endtask

    // busy drops for one cycle between queued operations: wait for two quiet samples
    task automatic wait_idle();
        int n;
        int quiet;
        n = 0;
        quiet = 0;
        while (quiet < 2 && n < 3000) begin
            @(posedge clk); #1; n++;
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
        end
        if (quiet < 2) begin
            err_count++;
            $display("mismatch busy expected 0 seen %b", busy);
            give_verdict();
        end
    endtask

    task automatic t_regs();
        reg_rd_op(8'h3A, rd); `CHK("control reset", 8'h00, rd)
        reg_wr_op(8'h3B, 8'h33); `CHK("busy after unmapped write", 1'b0, busy)
        reg_rd_op(8'h3B, rd); `CHK("unmapped read", 8'h00, rd)
        reg_wr_op(8'h3A, 8'hCC); `CHK("busy after non-trigger bits", 1'b0, busy)
        reg_rd_op(8'h3A, rd); `CHK("non-trigger bits ignored", 8'h00, rd)
        $display("test regs done");
    endtask

    task automatic t_load_erased();
        reg_wr_op(8'h3A, 8'h10); wait_idle();
        for (int i = 0; i < 16; i++) begin
            `CHK("page1 erased byte", 8'hFF, nvps_bank_model_i.mem[1 + i])
        end
        `CHK("byte below page1", 8'hFF, nvps_bank_model_i.mem[0])
        `CHK("byte of page2", 8'hEE, nvps_bank_model_i.mem[8'h11])
        $display("test load_erased done");
    endtask

    task automatic t_save_load(input logic [7:0] sbit, input logic [7:0] lbit,
                               input logic [7:0] base);
        reg_wr_op(8'h3A, lbit); wait_idle();
        for (int i = 0; i < 16; i++) nvps_bank_model_i.mem[base + i] = 8'hA0 ^ base ^ i[7:0];
        reg_wr_op(8'h3A, sbit); wait_idle();
        for (int i = 0; i < 16; i++) nvps_bank_model_i.mem[base + i] = 8'h00;
        reg_wr_op(8'h3A, lbit); wait_idle();
        for (int i = 0; i < 16; i++) begin
            rd = nvps_bank_model_i.mem[base + i];
            `CHK("restored byte", 8'hA0 ^ base ^ i[7:0], rd)
        end
        $display("test save_load page base %h done", base);
    endtask

    task automatic t_queue();
        reg_wr_op(8'h3A, 8'h20);
        reg_wr_op(8'h3A, 8'h01);
        reg_rd_op(8'h3A, rd); `CHK("pending and busy", 8'hA1, rd)
        wait_idle();
        reg_rd_op(8'h3A, rd); `CHK("control after queue", 8'h00, rd)
        $display("test queue done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk); #1;
        t_regs();
        t_load_erased();
        t_save_load(8'h01, 8'h10, 8'h01);
        t_save_load(8'h02, 8'h20, 8'h11);
        t_queue();
        give_verdict();
    end
endmodule
